// file: efoc_top.sv
// Erase and program control for an external serial flash, APB slave
//
// Overview of operation
// - Bit 12 enables the done interrupt
// - Bit 10 enables the error interrupt
// - Lock bit 7 resets set, blocks operations
// - Correct unlock sequence clears the lock
// - Writing one to lock relocks operations
// - Setting erase trigger starts selected erase
// - Trigger clears only when erase finishes
// - Bit 2 selects whole chip erase
// - Bit 1 selects sector erase at address
// - Bit 0 turns flash writes into programs
// - Done flag set on finish, write-one clears
// - Busy flag high while operation runs
// - Error flag set on protected access
`include "efoc_consts.svh"
`default_nettype none
module efoc_top
    import efoc_pkg::*;
#(
    parameter logic [31:0] KEY1 = `EFOC_KEY1, // First unlock key
    parameter logic [31:0] KEY2 = `EFOC_KEY2  // Second unlock key
) (
    input  wire logic        pclk,        // Bus clock
    input  wire logic        presetn,     // Async reset, active low
    input  wire logic        psel,        // APB select
    input  wire logic        penable,     // APB access phase
    input  wire logic        pwrite,      // APB direction, 1 is write
    input  wire logic [7:0]  paddr,       // APB byte address
    input  wire logic [31:0] pwdata,      // APB write data
    output logic [31:0]      prdata,      // APB read data
    output logic             pready,      // APB ready
    output logic             pslverr,     // APB error, unmapped address
    output logic             irq,         // Level interrupt request
    input  wire logic        prog_valid,  // Write to flash space offered
    input  wire logic [31:0] prog_addr,   // Flash space write address
    input  wire logic [31:0] prog_data,   // Flash space write data
    output logic             prog_ready,  // Flash space write accepted
    output logic             eng_valid,   // Command to flash engine
    output efoc_op_t         eng_kind,    // Command kind
    output logic [31:0]      eng_addr,    // Command address
    output logic [31:0]      eng_data,    // Command data
    input  wire logic        eng_ready,   // Engine took the command
    input  wire logic        eng_done     // Engine finished, one pulse
);

    // Whole state of the control block
    typedef struct packed {
        logic        done_ie;             // Done interrupt enable
        logic        err_ie;              // Error interrupt enable
        logic        lock;                // Operation lock
        logic        trig;                // Erase trigger
        logic        chip;                // Whole chip erase select
        logic        sector;              // Sector erase select
        logic        prog;                // Program select
        logic [31:0] eaddr;               // Sector erase address
        logic        done_f;              // Sticky done flag
        logic        perr_f;              // Sticky protection error
        logic [1:0]  mask;                // Interrupt mask, {done, err}
        logic        key_stage;           // First key seen
        logic        issued;              // Erase handed to sequencer
        logic [31:0] rdata;               // Read data latched in setup
    } efoc_main_t;

    // Reset image: locked, mask open, everything else clear
    localparam efoc_main_t ST_RST = '{
        done_ie: 1'b0, err_ie: 1'b0, lock: `EFOC_LOCK_RST,
        trig: 1'b0, chip: 1'b0, sector: 1'b0, prog: 1'b0,
        eaddr: `EFOC_EADDR_RST, done_f: 1'b0, perr_f: 1'b0,
        mask: `EFOC_MASK_RST, key_stage: 1'b0, issued: 1'b0,
        rdata: 32'h0000_0000
    };

    efoc_main_t r;                        // Registered state
    efoc_main_t nx;                       // Next state

    // Address match against one register offset, aligned words only
    function automatic logic efoc_hit(input logic [7:0] a,
                                      input logic [7:0] off);
        efoc_hit = (a == off);
    endfunction

    // Any mapped register at this address
    function automatic logic efoc_mapped(input logic [7:0] a);
        efoc_mapped = efoc_hit(a, `EFOC_OFF_CTRL)   |
                      efoc_hit(a, `EFOC_OFF_EADDR)  |
                      efoc_hit(a, `EFOC_OFF_STATUS) |
                      efoc_hit(a, `EFOC_OFF_UNLOCK) |
                      efoc_hit(a, `EFOC_OFF_MASK);
    endfunction

    // Sequencer handshake signals
    logic        seq_req_valid;           // Job offered to sequencer
    efoc_op_t    seq_req_kind;            // Kind of offered job
    logic [31:0] seq_req_addr;            // Address of offered job
    logic        seq_ready;               // Sequencer idle
    logic        seq_busy;                // Sequencer running a job
    logic        seq_done;                // Job finished pulse
    efoc_op_t    seq_done_kind;           // Kind of finished job

    // Bus and event terms
    logic        bus_wr;                  // Write completes this edge
    logic        bus_setup_rd;            // Read setup cycle
    logic        erase_pend;              // Erase waits for sequencer
    logic        prog_ok;                 // Flash writes become programs
    logic        prog_acc;                // Flash write accepted now
    logic        erase_end;               // Erase job finished now
    logic        busy;                    // Status busy flag
    logic        wr_ctrl;                 // Control register write
    logic        wr_unlock;               // Unlock register write

    // Zero wait state slave: every access phase completes at once
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~efoc_mapped(paddr);
    assign prdata  = r.rdata;

    assign bus_wr       = psel & penable & pwrite;
    assign bus_setup_rd = psel & ~penable & ~pwrite;
    assign wr_ctrl      = bus_wr & efoc_hit(paddr, `EFOC_OFF_CTRL);
    assign wr_unlock    = bus_wr & efoc_hit(paddr, `EFOC_OFF_UNLOCK);

    // A set trigger waits while relocked; erase goes before programs
    assign erase_pend = r.trig & ~r.issued & ~r.lock;
    assign prog_ok    = r.prog & ~r.lock;

    // Flash writes outside program mode, or locked, are taken and dropped
    assign prog_ready = ~erase_pend & (seq_ready | ~prog_ok);
    assign prog_acc   = prog_valid & prog_ready;

    // Offer to the sequencer: pending erase first, then a program
    assign seq_req_valid = erase_pend | (prog_valid & prog_ok & ~erase_pend);

    // Whole chip wins over sector when both are selected
    always_comb begin
        if (erase_pend) begin
            if (r.chip) begin
                seq_req_kind = OP_CHIP;
                seq_req_addr = 32'h0000_0000;
            end else begin
                seq_req_kind = OP_SECTOR;
                seq_req_addr = r.eaddr;
            end
        end else begin
            seq_req_kind = OP_PROG;
            seq_req_addr = prog_addr;
        end
    end

    assign erase_end = seq_done & (seq_done_kind != OP_PROG);
    assign busy      = r.trig | seq_busy;

    // Next state of registers, flags and read data
    always_comb begin
        logic done_set;                   // Done event this cycle
        logic perr_set;                   // Protection event this cycle
        logic done_clr;                   // Software clears done
        logic perr_clr;                   // Software clears error
        done_set = seq_done;
        perr_set = 1'b0;
        done_clr = 1'b0;
        perr_clr = 1'b0;
        nx = r;

        // Control register write; reserved bits are dropped
        if (wr_ctrl) begin
            nx.done_ie = pwdata[`EFOC_B_DONE_IE];
            nx.err_ie  = pwdata[`EFOC_B_ERR_IE];
            nx.chip    = pwdata[`EFOC_B_CHIP];
            nx.sector  = pwdata[`EFOC_B_SECTOR];
            nx.prog    = pwdata[`EFOC_B_PROG];
            // One relocks; zero leaves the lock to hardware
            if (pwdata[`EFOC_B_LOCK]) begin
                nx.lock      = 1'b1;
                nx.key_stage = 1'b0;
            end
            // Trigger: refused with an error while locked
            if (pwdata[`EFOC_B_TRIG] && !r.trig) begin
                if (r.lock || pwdata[`EFOC_B_LOCK]) begin
                    perr_set = 1'b1;
                end else if (pwdata[`EFOC_B_CHIP] ||
                             pwdata[`EFOC_B_SECTOR]) begin
                    nx.trig = 1'b1;
                end
            end
        end

        // Sector address, write-only
        if (bus_wr && efoc_hit(paddr, `EFOC_OFF_EADDR)) begin
            nx.eaddr = pwdata;
        end

        // Two keys in a row clear the lock; any other word restarts
        if (wr_unlock) begin
            if (r.key_stage && pwdata == KEY2) begin
                nx.lock      = 1'b0;
                nx.key_stage = 1'b0;
            end else begin
                nx.key_stage = (pwdata == KEY1);
            end
        end

        // Status write, one clears a flag
        if (bus_wr && efoc_hit(paddr, `EFOC_OFF_STATUS)) begin
            done_clr = pwdata[`EFOC_B_DONE_F];
            perr_clr = pwdata[`EFOC_B_PERR_F];
        end

        // Interrupt mask, same layout as status
        if (bus_wr && efoc_hit(paddr, `EFOC_OFF_MASK)) begin
            nx.mask = {pwdata[`EFOC_B_DONE_F], pwdata[`EFOC_B_PERR_F]};
        end

        // Flash write while locked in program mode hits protection
        if (prog_acc && r.prog && r.lock) begin
            perr_set = 1'b1;
        end

        // Erase handed over; trigger stays until the erase ends
        if (erase_pend && seq_ready) begin
            nx.issued = 1'b1;
        end
        if (erase_end) begin
            nx.trig   = 1'b0;
            nx.issued = 1'b0;
        end

        // Sticky flags: a set in the clearing cycle wins
        nx.done_f = (r.done_f & ~done_clr) | done_set;
        nx.perr_f = (r.perr_f & ~perr_clr) | perr_set;

        // Read data captured in the setup cycle
        if (bus_setup_rd) begin
            nx.rdata = 32'h0000_0000;
            if (efoc_hit(paddr, `EFOC_OFF_CTRL)) begin
                nx.rdata[`EFOC_B_DONE_IE] = r.done_ie;
                nx.rdata[`EFOC_B_ERR_IE]  = r.err_ie;
                nx.rdata[`EFOC_B_LOCK]    = r.lock;
                nx.rdata[`EFOC_B_TRIG]    = r.trig;
                nx.rdata[`EFOC_B_CHIP]    = r.chip;
                nx.rdata[`EFOC_B_SECTOR]  = r.sector;
                nx.rdata[`EFOC_B_PROG]    = r.prog;
            end else if (efoc_hit(paddr, `EFOC_OFF_STATUS)) begin
                nx.rdata[`EFOC_B_DONE_F] = r.done_f;
                nx.rdata[`EFOC_B_PERR_F] = r.perr_f;
                nx.rdata[`EFOC_B_BUSY_F] = busy;
            end else if (efoc_hit(paddr, `EFOC_OFF_MASK)) begin
                nx.rdata[`EFOC_B_DONE_F] = r.mask[1];
                nx.rdata[`EFOC_B_PERR_F] = r.mask[0];
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= ST_RST;
        end else begin
            r <= nx;
        end
    end

    // Interrupt: enabled and unmasked done or error flag
    assign irq = (r.done_f & r.done_ie & r.mask[1]) |
                 (r.perr_f & r.err_ie & r.mask[0]);

    // Job sequencer toward the flash engine
    efoc_seq #(
        .AW        (32)
    ) u_seq (
        .pclk      (pclk),
        .presetn   (presetn),
        .req_valid (seq_req_valid),
        .req_kind  (seq_req_kind),
        .req_addr  (seq_req_addr),
        .req_data  (prog_data),
        .req_ready (seq_ready),
        .busy      (seq_busy),
        .done      (seq_done),
        .done_kind (seq_done_kind),
        .eng_valid (eng_valid),
        .eng_kind  (eng_kind),
        .eng_addr  (eng_addr),
        .eng_data  (eng_data),
        .eng_ready (eng_ready),
        .eng_done  (eng_done)
    );

    // No job is handed to the sequencer while locked
    AST_LOCK_BLOCKS: assert property (@(posedge pclk) disable iff (!presetn)
        r.lock |-> !(seq_req_valid && seq_ready))
        else $error("job offered while locked");

    // Correct second key clears the lock on the next edge
    AST_UNLOCK: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_unlock && r.key_stage && pwdata == KEY2) |=> !r.lock)
        else $error("lock still set after correct keys");

    // Writing one to the lock bit relocks
    AST_RELOCK: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ctrl && pwdata[`EFOC_B_LOCK]) |=> r.lock)
        else $error("lock not set by software write");

    // A pending unlocked erase reaches an idle sequencer at once
    AST_TRIG_START: assert property (@(posedge pclk) disable iff (!presetn)
        (erase_pend && seq_ready) |=> (seq_busy && r.issued))
        else $error("erase trigger did not start the sequencer");

    // Trigger holds until the erase job reports its end
    AST_TRIG_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (r.trig && !erase_end) |=> r.trig)
        else $error("erase trigger dropped before erase ended");

    // Whole chip selection yields a chip erase job
    AST_CHIP_KIND: assert property (@(posedge pclk) disable iff (!presetn)
        (erase_pend && r.chip && seq_ready) |=> eng_kind == OP_CHIP)
        else $error("chip erase not issued as chip erase");

    // Sector erase carries the loaded sector address
    AST_SECT_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
        (erase_pend && !r.chip && seq_ready)
            |=> (eng_kind == OP_SECTOR && eng_addr == $past(r.eaddr)))
        else $error("sector erase address wrong");

    // Every finished job leaves the done flag set
    AST_DONE_SET: assert property (@(posedge pclk) disable iff (!presetn)
        seq_done |=> r.done_f)
        else $error("done flag not set on finish");

    // Refused trigger raises the protection error
    AST_PERR_SET: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ctrl && pwdata[`EFOC_B_TRIG] && r.lock && !r.trig)
            |=> (r.perr_f && !r.trig))
        else $error("locked trigger not refused with error");

    // Interrupt follows an enabled done flag, silent with both disabled
    AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        ((r.done_f && r.done_ie && r.mask[1]) |-> irq) and
        ((!r.done_ie && !r.err_ie) |-> !irq))
        else $error("interrupt level wrong");

endmodule
`default_nettype wire

// file: efoc_consts.svh
// Offsets, bit positions, reset values and keys of the flash op control
`ifndef EFOC_CONSTS_SVH
`define EFOC_CONSTS_SVH

// Register byte offsets on the APB
`define EFOC_OFF_CTRL    8'h00
`define EFOC_OFF_EADDR   8'h04
`define EFOC_OFF_STATUS  8'h08
`define EFOC_OFF_UNLOCK  8'h0c
`define EFOC_OFF_MASK    8'h10

// Control register bit positions
`define EFOC_B_DONE_IE   12
`define EFOC_B_ERR_IE    10
`define EFOC_B_LOCK      7
`define EFOC_B_TRIG      6
`define EFOC_B_CHIP      2
`define EFOC_B_SECTOR    1
`define EFOC_B_PROG      0

// Status and mask register bit positions
`define EFOC_B_DONE_F    5
`define EFOC_B_PERR_F    4
`define EFOC_B_BUSY_F    0

// Reset values
`define EFOC_LOCK_RST    1'h1
`define EFOC_MASK_RST    2'h3
`define EFOC_EADDR_RST   32'h0000_0000

// Unlock keys, first then second; values are arbitrary
`define EFOC_KEY1        32'h5a17_c3e1
`define EFOC_KEY2        32'h0e6b_92d4

`endif

// file: efoc_pkg.sv
// Types shared by the flash op control and its sequencer
`default_nettype none
package efoc_pkg;

    // Job kinds handed to the flash engine
    typedef enum logic [1:0] {
        OP_CHIP   = 2'b00,
        OP_SECTOR = 2'b01,
        OP_PROG   = 2'b10
    } efoc_op_t;

    // Sequencer states
    typedef enum logic [1:0] {
        SQ_IDLE  = 2'b00,
        SQ_ISSUE = 2'b01,
        SQ_WAIT  = 2'b10
    } efoc_sq_t;

endpackage
`default_nettype wire

// file: efoc_seq.sv
// Sequencer that hands one erase or program job at a time to the engine
`default_nettype none
module efoc_seq
    import efoc_pkg::*;
#(
    parameter int AW = 32                   // Address and data width
) (
    input  wire logic          pclk,        // Bus clock
    input  wire logic          presetn,     // Async reset, active low
    input  wire logic          req_valid,   // Job offered
    input  wire efoc_op_t      req_kind,    // Kind of offered job
    input  wire logic [AW-1:0] req_addr,    // Job address
    input  wire logic [AW-1:0] req_data,    // Program data
    output logic               req_ready,   // Idle, offered job is taken
    output logic               busy,        // Job in progress
    output logic               done,        // One-cycle finish pulse
    output efoc_op_t           done_kind,   // Kind of the finished job
    output logic               eng_valid,   // Command to the engine
    output efoc_op_t           eng_kind,    // Command kind
    output logic [AW-1:0]      eng_addr,    // Command address
    output logic [AW-1:0]      eng_data,    // Command data
    input  wire logic          eng_ready,   // Engine took the command
    input  wire logic          eng_done     // Engine finished the job
);

    // Whole sequencer state
    typedef struct packed {
        efoc_sq_t      state;               // Current step
        efoc_op_t      kind;                // Latched job kind
        logic [AW-1:0] addr;                // Latched address
        logic [AW-1:0] data;                // Latched data
        logic          done;                // Finish pulse
    } efoc_sq_st_t;

    efoc_sq_st_t r;                         // Registered state
    efoc_sq_st_t nx;                        // Next state

    // Step through issue and wait; job fields hold until finish
    always_comb begin
        nx = r;
        nx.done = 1'b0;
        unique case (r.state)
            SQ_IDLE: begin
                if (req_valid) begin
                    nx.state = SQ_ISSUE;
                    nx.kind  = req_kind;
                    nx.addr  = req_addr;
                    nx.data  = req_data;
                end
            end
            SQ_ISSUE: begin
                if (eng_ready) begin
                    nx.state = SQ_WAIT;
                end
            end
            SQ_WAIT: begin
                // Finish reported by the engine ends the job
                if (eng_done) begin
                    nx.state = SQ_IDLE;
                    nx.done  = 1'b1;
                end
            end
            default: begin
                // Unused code recovers to idle
                nx.state = SQ_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= nx;
        end
    end

    assign req_ready = (r.state == SQ_IDLE);
    assign busy      = (r.state != SQ_IDLE);
    assign done      = r.done;
    assign done_kind = r.kind;
    assign eng_valid = (r.state == SQ_ISSUE);
    assign eng_kind  = r.kind;
    assign eng_addr  = r.addr;
    assign eng_data  = r.data;

    // A finish pulse lasts one cycle and leaves the sequencer idle
    AST_SQ_DONE_ONCE: assert property (@(posedge pclk) disable iff (!presetn)
        done |-> (req_ready ##1 !done))
        else $error("finish pulse longer than one cycle");

    // A pending command holds still until the engine takes it
    AST_SQ_CMD_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (eng_valid && !eng_ready) |=> (eng_valid && $stable(eng_addr)))
        else $error("engine command changed before it was taken");

endmodule
`default_nettype wire

// file: efoc_eng_model.sv
// Behavioural flash engine: takes one job, reports its end by a pulse
`default_nettype none
module efoc_eng_model
    import efoc_pkg::*;
(
    input  wire logic        pclk,      // Bus clock
    input  wire logic        presetn,   // Async reset, active low
    input  wire logic        slow,      // Stretch the job time
    input  wire logic        eng_valid, // Command offered
    input  wire efoc_op_t    eng_kind,  // Command kind
    input  wire logic [31:0] eng_addr,  // Command address
    input  wire logic [31:0] eng_data,  // Command data
    output logic             eng_ready, // Idle, command taken
    output logic             eng_done,  // One-cycle finish pulse
    output efoc_op_t         last_kind, // Kind of last job
    output logic [31:0]      last_addr, // Address of last job
    output logic [31:0]      last_data, // Data of last job
    output logic [7:0]       n_jobs     // Jobs taken so far
);
    logic       active; // Job in flight
    logic [3:0] cnt;    // Cycles left in the job

    // One job at a time, so ready only while idle
    assign eng_ready = !active;

    // Take a job, count down, then pulse done
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active <= 1'b0;
            cnt <= 4'h0;
            eng_done <= 1'b0;
            last_kind <= OP_CHIP;
            last_addr <= 32'h0;
            last_data <= 32'h0;
            n_jobs <= 8'h0;
        end else begin
            eng_done <= 1'b0;
            if (eng_valid && eng_ready) begin
                active <= 1'b1;
                cnt <= slow ? 4'hc : 4'h3;
                last_kind <= eng_kind;
                last_addr <= eng_addr;
                last_data <= eng_data;
                n_jobs <= n_jobs + 8'h1;
            end else if (active && cnt == 4'h0) begin
                eng_done <= 1'b1;
                active <= 1'b0;
            end else if (active) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// file: tb_efoc_top.sv
// Register-level bench for the flash op control with an engine model
`include "efoc_consts.svh"
`default_nettype none
module tb_efoc_top import efoc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        prog_valid = 0, slow = 0, err;
    logic [7:0]  paddr = 0, n_jobs;
    logic [31:0] pwdata = 0, prog_addr = 0, prog_data = 0, rdata, cv;
    logic [31:0] prdata, eng_addr, eng_data, last_addr, last_data;
    logic        pready, pslverr, irq, prog_ready, eng_valid, eng_ready;
    logic        eng_done;
    efoc_op_t    eng_kind, last_kind;
    int          n_fail = 0, compares = 0, cycles = 0, i, k;

    efoc_top efoc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .prog_valid(prog_valid),
        .prog_addr(prog_addr), .prog_data(prog_data),
        .prog_ready(prog_ready), .eng_valid(eng_valid),
        .eng_kind(eng_kind), .eng_addr(eng_addr), .eng_data(eng_data),
        .eng_ready(eng_ready), .eng_done(eng_done));
    efoc_eng_model efoc_eng_model_i (.pclk(pclk), .presetn(presetn),
        .slow(slow), .eng_valid(eng_valid), .eng_kind(eng_kind),
        .eng_addr(eng_addr), .eng_ready(eng_ready), .eng_done(eng_done),
        .eng_data(eng_data), .last_data(last_data),
        .last_kind(last_kind), .last_addr(last_addr), .n_jobs(n_jobs));

    // 50 MHz clock
    always #10 pclk = ~pclk;

    task automatic results();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Cut a hang short
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            results();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask

    // APB transfer; leaves the bus for the next setup or idle()
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdata = prdata;
        err = pslverr;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
        apb(a, 1'b0, 32'h0);
        chk(nm, e, rdata);
    endtask

    task automatic idle(input int n);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge pclk);
    endtask

    // Poll status until the done flag shows, bounded
    task automatic wait_done();
        k = 0;
        do begin
            apb(`EFOC_OFF_STATUS, 1'b0, 32'h0);
            k++;
        end while (rdata[`EFOC_B_DONE_F] !== 1'b1 && k < 40);
    endtask

    task automatic prog_wr(input logic [31:0] a);
        prog_valid <= 1'b1;
        prog_addr <= a;
        prog_data <= ~a;
        @(posedge pclk);
        while (prog_ready !== 1'b1) @(posedge pclk);
        prog_valid <= 1'b0;
        @(posedge pclk);
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`EFOC_OFF_CTRL, 32'h80, "ctrl reset");
        rd(`EFOC_OFF_MASK, 32'h30, "mask reset");
        rd(`EFOC_OFF_STATUS, 32'h0, "status reset");
        rd(`EFOC_OFF_EADDR, 32'h0, "addr read");
        rd(8'h14, 32'h0, "unmapped");
        chk("slverr", 32'h1, {31'h0, err});
        // Erase start while locked is refused and flags an error
        apb(`EFOC_OFF_CTRL, 1'b1, 32'h444);
        rd(`EFOC_OFF_CTRL, 32'h484, "locked ctrl");
        rd(`EFOC_OFF_STATUS, 32'h10, "prot error");
        chk("irq err", 32'h1, {31'h0, irq});
        apb(`EFOC_OFF_STATUS, 1'b1, 32'h10);
        idle(1);
        chk("irq clear", 32'h0, {31'h0, irq});
        // A stray key restarts the sequence
        apb(`EFOC_OFF_UNLOCK, 1'b1, `EFOC_KEY1);
        apb(`EFOC_OFF_UNLOCK, 1'b1, 32'h0);
        apb(`EFOC_OFF_UNLOCK, 1'b1, `EFOC_KEY2);
        rd(`EFOC_OFF_CTRL, 32'h484, "bad key");
        apb(`EFOC_OFF_UNLOCK, 1'b1, `EFOC_KEY1);
        apb(`EFOC_OFF_UNLOCK, 1'b1, `EFOC_KEY2);
        rd(`EFOC_OFF_CTRL, 32'h404, "unlocked");
        // Chip erase slow with done irq off, then sector erase fast
        for (i = 0; i < 2; i++) begin
            slow <= (i == 0);
            cv = (i == 0) ? 32'h0444 : 32'h1042;
            apb(`EFOC_OFF_EADDR, 1'b1, 32'h0004_2a40);
            apb(`EFOC_OFF_CTRL, 1'b1, cv);
            if (i == 0) begin
                idle(2);
                rd(`EFOC_OFF_CTRL, cv, "erase running");
                rd(`EFOC_OFF_STATUS, 32'h1, "busy");
            end
            wait_done();
            chk("done", 32'h20, rdata);
            rd(`EFOC_OFF_CTRL, cv & ~32'h40, "erase over");
            chk("kind", {30'h0, i ? OP_SECTOR : OP_CHIP},
                {30'h0, last_kind});
            chk("addr", i ? 32'h0004_2a40 : 32'h0, last_addr);
            chk("irq done", i, {31'h0, irq});
            apb(`EFOC_OFF_MASK, 1'b1, 32'h10);
            idle(1);
            chk("irq masked", 32'h0, {31'h0, irq});
            apb(`EFOC_OFF_STATUS, 1'b1, 32'h20);
            apb(`EFOC_OFF_MASK, 1'b1, 32'h30);
        end
        // Program while unlocked reaches the engine
        apb(`EFOC_OFF_CTRL, 1'b1, 32'h1);
        idle(1);
        prog_wr(32'h0010_0008);
        wait_done();
        chk("prog done", 32'h20, rdata);
        chk("prog kind", {30'h0, OP_PROG}, {30'h0, last_kind});
        chk("prog addr", 32'h0010_0008, last_addr);
        chk("prog data", ~32'h0010_0008, last_data);
        apb(`EFOC_OFF_STATUS, 1'b1, 32'h20);
        // Relock, then a program is dropped and flagged
        apb(`EFOC_OFF_CTRL, 1'b1, 32'h81);
        rd(`EFOC_OFF_CTRL, 32'h81, "relocked");
        idle(1);
        prog_wr(32'h0010_000c);
        rd(`EFOC_OFF_STATUS, 32'h10, "prot prog");
        chk("jobs", 32'h3, {24'h0, n_jobs});
        results();
    end
endmodule
`default_nettype wire
